//--- rtl/exec_regs.vh
/*
 Constants for the branch, skip and bit-operation execution unit:
 operation codes, status flag positions, reset values and cycle counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH
// Operation codes
`define OP_W 6
`define OP_TEST 6'h00
`define OP_ZERO 6'h01
`define OP_ONES 6'h02
`define OP_REL_JUMP 6'h03
`define OP_PTR_JUMP 6'h04
`define OP_REL_CALL 6'h05
`define OP_PTR_CALL 6'h06
`define OP_SUB_RETURN 6'h07
`define OP_IRQ_RETURN 6'h08
`define OP_CMP_SKIP_EQ 6'h09
`define OP_CMP 6'h0a
`define OP_CMP_CARRY 6'h0b
`define OP_CMP_IMM 6'h0c
`define OP_SKIP_REGBIT_CLR 6'h0d
`define OP_SKIP_REGBIT_SET 6'h0e
`define OP_SKIP_IOBIT_CLR 6'h0f
`define OP_SKIP_IOBIT_SET 6'h10
`define OP_BRANCH_FLAG_SET 6'h11
`define OP_BRANCH_FLAG_CLR 6'h12
`define OP_BRANCH_EQ 6'h13
`define OP_BRANCH_NE 6'h14
`define OP_BRANCH_CARRY_SET 6'h15
`define OP_BRANCH_CARRY_CLR 6'h16
`define OP_BRANCH_SAME_HIGHER 6'h17
`define OP_BRANCH_LOWER 6'h18
`define OP_BRANCH_MINUS 6'h19
`define OP_BRANCH_PLUS 6'h1a
`define OP_BRANCH_GE_SIGNED 6'h1b
`define OP_BRANCH_LT_SIGNED 6'h1c
`define OP_BRANCH_HALFCARRY_SET 6'h1d
`define OP_BRANCH_HALFCARRY_CLR 6'h1e
`define OP_BRANCH_TBIT_SET 6'h1f
`define OP_BRANCH_TBIT_CLR 6'h20
`define OP_BRANCH_OVF_SET 6'h21
`define OP_BRANCH_OVF_CLR 6'h22
`define OP_BRANCH_IRQ_ON 6'h23
`define OP_BRANCH_IRQ_OFF 6'h24
`define OP_SET_IOBIT 6'h25
`define OP_CLEAR_IOBIT 6'h26
`define OP_SHIFT_LEFT 6'h27
`define OP_SHIFT_RIGHT 6'h28
`define OP_ROTATE_LEFT_CARRY 6'h29
// Status flag positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
// Reset values and the value the set operation loads
`define PC_RESET 16'h0000
`define FLAGS_RESET 8'h00
`define SP_RESET 4'h0
`define ONES_VALUE 8'hff
// Cycle counts
`define CYC_ONE 2'h1
`define CYC_JUMP 2'h2
`define CYC_CALL 2'h3
`define CYC_RETURN 3'h4
`define CYC_SKIP1 2'h2
`define CYC_SKIP2 2'h3
`define CYC_BRANCH_TAKEN 2'h2
`define CYC_IOBIT 2'h2
// Return stack
`define STACK_AW 4
`define STACK_DEPTH 16
`endif

//--- rtl/exec_alu.v
/*
 Result and flag values for the register test, clear, set, compare
 and shift operations. Purely combinational.
 Assumes the caller selects which flags it keeps.
*/
`default_nettype none
`include "exec_regs.vh"
module exec_alu (
  // Operation and operands
  input wire [`OP_W-1:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire carry_in,
  input wire zero_in,
  // Results
  output reg [7:0] result,
  output reg flag_c,
  output reg flag_z,
  output reg flag_n,
  output reg flag_v,
  output reg flag_h
);
  reg [8:0] diff;
  always @*
  begin
    diff = {1'b0, a} - {1'b0, b} - {8'h00, (op == `OP_CMP_CARRY) & carry_in};
    result = 8'h00;
    flag_c = carry_in;
    flag_h = 1'b0;
    flag_v = 1'b0;
    case (op)
      `OP_TEST: result = a & a;
      `OP_ZERO: result = a ^ a;
      `OP_ONES: result = `ONES_VALUE;
      `OP_CMP, `OP_CMP_CARRY, `OP_CMP_IMM:
      begin
        result = diff[7:0];
        flag_c = diff[8];
        flag_h = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
        flag_v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
      end
      `OP_SHIFT_LEFT:
      begin
        result = {a[6:0], 1'b0};
        flag_c = a[7];
      end
      `OP_SHIFT_RIGHT:
      begin
        result = {1'b0, a[7:1]};
        flag_c = a[0];
      end
      `OP_ROTATE_LEFT_CARRY:
      begin
        result = {a[6:0], carry_in};
        flag_c = a[7];
      end
      default: result = 8'h00;
    endcase
    flag_n = result[7];
    if (op == `OP_SHIFT_LEFT || op == `OP_SHIFT_RIGHT || op == `OP_ROTATE_LEFT_CARRY)
      flag_v = result[7] ^ flag_c;
    flag_z = (result == 8'h00) & ((op != `OP_CMP_CARRY) | zero_in);
  end
endmodule // exec_alu
`default_nettype wire

//--- rtl/branch_skip_bitop_exec.v
/*
 Execution unit for register test/clear/set, jumps, calls, returns,
 compare and skip, flag branches, I/O bit set/clear and left/right shifts.
 Assumes the fetch stage presents one decoded operation with its operands,
 all on the same clock, and holds it until op_ready.
*/
// What this block does
// - Test ANDs, clear XORs register with itself updating Z,N,V; set loads 0xff; 1 cycle.
// - Relative jump to PC+k+1, pointer jump to Z; 2 cycles, flags kept.
// - Relative call to PC+k+1, pointer call to Z; push return; 3 cycles.
// - Compare-skip-equal skips next when equal; PC+2 or +3; 1/2/3 cycles.
// - Compares subtract without storing, update Z,N,V,C,H; carry form subtracts C; 1 cycle.
// - Register bit skips test chosen bit, skip on match; 1/2/3 cycles, flags kept.
// - I/O bit skips test addressed I/O bit, skip on match; 1/2/3 cycles.
// - Generic flag branches test chosen status bit; taken to PC+k+1; 1 or 2 cycles.
// - Carry-set and lower branch on C=1; carry-clear and same-higher on C=0.
// - Signed branches use N xor V; ge when 0, lt when 1; 1 or 2 cycles.
// - Half-carry branches taken on H set or clear; relative target; 1 or 2 cycles.
// - T branches taken on T set or clear; 1 or 2 cycles; flags kept.
// - Overflow branches taken on V set or clear; 1 or 2 cycles; flags kept.
// - Interrupt-state branches taken on I one or zero; 1 or 2 cycles.
// - I/O bit set and clear force the addressed bit; 2 cycles; flags kept.
// - Rotate left loads bit 0 from carry, old bit 7 to carry; Z,C,N,V; 1 cycle.
`default_nettype none
`include "exec_regs.vh"
module branch_skip_bitop_exec (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Operation request
  input wire op_valid,
  output wire op_ready,
  input wire [`OP_W-1:0] op_code,
  input wire [7:0] rd_value,
  input wire [7:0] rr_value,
  input wire [7:0] imm_value,
  input wire [2:0] bit_sel,
  input wire [11:0] rel_offset,
  input wire [15:0] z_pointer,
  input wire next_two_word,
  // I/O register access
  input wire [4:0] io_addr,
  input wire [7:0] io_rdata,
  output reg io_we,
  output reg [4:0] io_waddr,
  output reg [7:0] io_wdata,
  // Register write-back
  output reg reg_we,
  output reg [7:0] reg_wdata,
  // Core state
  output reg [15:0] pc,
  output reg [7:0] status_flags_register
);
  reg [15:0] pc_q;
  reg [15:0] pc_d;
  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg [2:0] wait_q;
  reg [2:0] wait_d;
  reg [`STACK_AW-1:0] sp_q;
  reg [`STACK_AW-1:0] sp_d;
  // Return stack, no reset; a return before any call gives unknown pc
  reg [15:0] stack_mem [0:`STACK_DEPTH-1];
  reg push;
  reg reg_we_d;
  reg [7:0] reg_wdata_d;
  reg io_we_d;
  reg [7:0] io_wdata_d;
  reg take;
  reg [2:0] cyc;
  wire [7:0] alu_result;
  wire alu_c;
  wire alu_z;
  wire alu_n;
  wire alu_v;
  wire alu_h;
  wire accept;
  wire [15:0] pc_next;
  wire [15:0] pc_rel;
  wire [15:0] top_of_stack;
  wire [7:0] alu_b;

  // Relative target: PC plus signed offset plus one
  function [15:0] rel_target;
    input [15:0] base;
    input [11:0] k;
    begin
      rel_target = base + {{4{k[11]}}, k} + 16'h0001;
    end
  endfunction

  // Skip length and cycle count for a taken or untaken skip
  function [18:0] skip_outcome;
    input [15:0] base;
    input hit;
    input two_word;
    begin
      if (!hit)
        skip_outcome = {1'b0, `CYC_ONE, base + 16'h0001};
      else if (two_word)
        skip_outcome = {1'b0, `CYC_SKIP2, base + 16'h0003};
      else
        skip_outcome = {1'b0, `CYC_SKIP1, base + 16'h0002};
    end
  endfunction

  // Ready while no multi-cycle operation counts down
  assign op_ready = (wait_q == 3'h0);
  assign accept = op_valid & op_ready;
  assign pc_next = pc_q + 16'h0001;
  assign pc_rel = rel_target(pc_q, rel_offset);
  assign top_of_stack = stack_mem[sp_q - 4'h1];
  // Operand b: immediate only for compare-immediate
  assign alu_b = (op_code == `OP_CMP_IMM) ? imm_value : rr_value;

  // Shared result and flag logic
  exec_alu u_alu (
    .op(op_code),
    .a(rd_value),
    .b(alu_b),
    .carry_in(flags_q[`FLAG_C]),
    .zero_in(flags_q[`FLAG_Z]),
    .result(alu_result),
    .flag_c(alu_c),
    .flag_z(alu_z),
    .flag_n(alu_n),
    .flag_v(alu_v),
    .flag_h(alu_h)
  );

  // Next-state decode for the operation on the bus
  always @*
  begin
    pc_d = pc_next;
    flags_d = flags_q;
    sp_d = sp_q;
    push = 1'b0;
    reg_we_d = 1'b0;
    reg_wdata_d = alu_result;
    io_we_d = 1'b0;
    io_wdata_d = io_rdata;
    take = 1'b0;
    cyc = {1'b0, `CYC_ONE};
    case (op_code)
      `OP_TEST, `OP_ZERO:
      begin
        reg_we_d = (op_code == `OP_ZERO);
        flags_d[`FLAG_Z] = alu_z;
        flags_d[`FLAG_N] = alu_n;
        flags_d[`FLAG_V] = alu_v;
      end
      `OP_ONES: reg_we_d = 1'b1;
      `OP_REL_JUMP, `OP_PTR_JUMP:
      begin
        pc_d = (op_code == `OP_REL_JUMP) ? pc_rel : z_pointer;
        cyc = {1'b0, `CYC_JUMP};
      end
      `OP_REL_CALL, `OP_PTR_CALL:
      begin
        pc_d = (op_code == `OP_REL_CALL) ? pc_rel : z_pointer;
        push = 1'b1;
        sp_d = sp_q + 4'h1;
        cyc = {1'b0, `CYC_CALL};
      end
      `OP_SUB_RETURN, `OP_IRQ_RETURN:
      begin
        pc_d = top_of_stack;
        sp_d = sp_q - 4'h1;
        cyc = `CYC_RETURN;
        if (op_code == `OP_IRQ_RETURN)
          flags_d[`FLAG_I] = 1'b1;
      end
      `OP_CMP_SKIP_EQ:
        {cyc, pc_d} = skip_outcome(pc_q, rd_value == rr_value, next_two_word);
      `OP_CMP, `OP_CMP_CARRY, `OP_CMP_IMM:
      begin
        flags_d[`FLAG_Z] = alu_z;
        flags_d[`FLAG_N] = alu_n;
        flags_d[`FLAG_V] = alu_v;
        flags_d[`FLAG_C] = alu_c;
        flags_d[`FLAG_H] = alu_h;
      end
      `OP_SKIP_REGBIT_CLR, `OP_SKIP_REGBIT_SET:
        {cyc, pc_d} = skip_outcome(pc_q, rr_value[bit_sel] == (op_code == `OP_SKIP_REGBIT_SET),
          next_two_word);
      `OP_SKIP_IOBIT_CLR, `OP_SKIP_IOBIT_SET:
        {cyc, pc_d} = skip_outcome(pc_q, io_rdata[bit_sel] == (op_code == `OP_SKIP_IOBIT_SET),
          next_two_word);
      // Conditional branches decide take only; target and length follow the case
      `OP_BRANCH_FLAG_SET: take = flags_q[bit_sel];
      `OP_BRANCH_FLAG_CLR: take = ~flags_q[bit_sel];
      `OP_BRANCH_EQ: take = flags_q[`FLAG_Z];
      `OP_BRANCH_NE: take = ~flags_q[`FLAG_Z];
      `OP_BRANCH_MINUS: take = flags_q[`FLAG_N];
      `OP_BRANCH_PLUS: take = ~flags_q[`FLAG_N];
      `OP_BRANCH_CARRY_SET, `OP_BRANCH_LOWER: take = flags_q[`FLAG_C];
      `OP_BRANCH_CARRY_CLR, `OP_BRANCH_SAME_HIGHER: take = ~flags_q[`FLAG_C];
      `OP_BRANCH_GE_SIGNED: take = ~(flags_q[`FLAG_N] ^ flags_q[`FLAG_V]);
      `OP_BRANCH_LT_SIGNED: take = flags_q[`FLAG_N] ^ flags_q[`FLAG_V];
      `OP_BRANCH_HALFCARRY_SET: take = flags_q[`FLAG_H];
      `OP_BRANCH_HALFCARRY_CLR: take = ~flags_q[`FLAG_H];
      `OP_BRANCH_TBIT_SET: take = flags_q[`FLAG_T];
      `OP_BRANCH_TBIT_CLR: take = ~flags_q[`FLAG_T];
      `OP_BRANCH_OVF_SET: take = flags_q[`FLAG_V];
      `OP_BRANCH_OVF_CLR: take = ~flags_q[`FLAG_V];
      `OP_BRANCH_IRQ_ON: take = flags_q[`FLAG_I];
      `OP_BRANCH_IRQ_OFF: take = ~flags_q[`FLAG_I];
      `OP_SET_IOBIT, `OP_CLEAR_IOBIT:
      begin
        io_we_d = 1'b1;
        io_wdata_d[bit_sel] = (op_code == `OP_SET_IOBIT);
        cyc = {1'b0, `CYC_IOBIT};
      end
      `OP_SHIFT_LEFT, `OP_SHIFT_RIGHT, `OP_ROTATE_LEFT_CARRY:
      begin
        reg_we_d = 1'b1;
        flags_d[`FLAG_Z] = alu_z;
        flags_d[`FLAG_C] = alu_c;
        flags_d[`FLAG_N] = alu_n;
        flags_d[`FLAG_V] = alu_v;
      end
      // Undefined codes only advance the pc
      default: pc_d = pc_next;
    endcase
    // Conditional branch: taken costs one extra cycle
    if (take)
    begin
      pc_d = pc_rel;
      cyc = {1'b0, `CYC_BRANCH_TAKEN};
    end
    // Ready again cyc-1 clocks after the taking edge
    wait_d = cyc - 3'h1;
  end

  // Return address stack
  // Held off in reset so a waiting request cannot write an entry
  always @(posedge clock)
  begin
    if (accept && push && !rst)
      stack_mem[sp_q] <= pc_next;
  end

  // State and registered outputs; a taken operation loads them, otherwise pulses drop and the wait counter runs down
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pc_q <= `PC_RESET;
      flags_q <= `FLAGS_RESET;
      sp_q <= `SP_RESET;
      wait_q <= 3'h0;
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      io_we <= 1'b0;
      io_waddr <= 5'h00;
      io_wdata <= 8'h00;
    end
    else if (accept)
    begin
      pc_q <= pc_d;
      flags_q <= flags_d;
      sp_q <= sp_d;
      wait_q <= wait_d;
      reg_we <= reg_we_d;
      reg_wdata <= reg_wdata_d;
      io_we <= io_we_d;
      io_waddr <= io_addr;
      io_wdata <= io_wdata_d;
    end
    else
    begin
      // Pulses drop, wait counter runs down
      reg_we <= 1'b0;
      io_we <= 1'b0;
      if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
    end
  end

  // Port copies of the state registers
  always @*
  begin
    pc = pc_q;
    status_flags_register = flags_q;
  end
endmodule // branch_skip_bitop_exec
`default_nettype wire

//--- verification/exec_chk.sv
/*
 Concurrent checks on the execution unit's ports.
 Assumes binding to branch_skip_bitop_exec and exec_regs.vh on the include path.
*/
`default_nettype none
`include "exec_regs.vh"
module exec_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Operation request
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [5:0] op_code,
  input wire logic [7:0] rd_value,
  input wire logic [2:0] bit_sel,
  input wire logic [11:0] rel_offset,
  input wire logic [15:0] z_pointer,
  // I/O and write-back
  input wire logic [4:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic io_we,
  input wire logic [4:0] io_waddr,
  input wire logic [7:0] io_wdata,
  input wire logic reg_we,
  input wire logic [7:0] reg_wdata,
  // Core state
  input wire logic [15:0] pc,
  input wire logic [7:0] status_flags_register
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = op_valid && op_ready;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  rel_jump_pc_a: assert property (take && op_code == `OP_REL_JUMP
    |=> pc == $past(pc) + {{4{$past(rel_offset[11])}}, $past(rel_offset)} + 16'h1) else $error("jump target");
  jump_wait_a: assert property (take && (op_code == `OP_REL_JUMP || op_code == `OP_PTR_JUMP)
    |=> !op_ready ##1 op_ready) else $error("jump length");
  ptr_call_pc_a: assert property (take && op_code == `OP_PTR_CALL
    |=> pc == $past(z_pointer)) else $error("call target");
  call_wait_a: assert property (take && (op_code == `OP_REL_CALL || op_code == `OP_PTR_CALL)
    |=> !op_ready [*2] ##1 op_ready) else $error("call length");
  return_wait_a: assert property (take && (op_code == `OP_SUB_RETURN || op_code == `OP_IRQ_RETURN)
    |=> !op_ready [*3] ##1 op_ready) else $error("return length");
  irq_ret_flag_a: assert property (take && op_code == `OP_IRQ_RETURN
    |=> status_flags_register[`FLAG_I]) else $error("interrupt flag");
  ones_flags_a: assert property (take && op_code == `OP_ONES
    |=> reg_we && reg_wdata == `ONES_VALUE && $stable(status_flags_register)) else $error("ones write");
  iobit_write_a: assert property (take && op_code == `OP_SET_IOBIT
    |=> io_we && io_waddr == $past(io_addr) && io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_sel))))
    else $error("bit set write");
  shift_left_a: assert property (take && op_code == `OP_SHIFT_LEFT
    |=> reg_wdata == {$past(rd_value[6:0]), 1'b0} && status_flags_register[`FLAG_C] == $past(rd_value[7]))
    else $error("shift left");
endmodule // exec_chk
`default_nettype wire

//--- verification/branch_skip_bitop_exec_tb.sv
/*
 Self-checking bench for the execution unit, one task per scenario.
 Assumes exec_regs.vh on the include path.
*/
`default_nettype none
`include "exec_regs.vh"
module branch_skip_bitop_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, op_valid, next_two_word, we_s, iowe_s;
  logic [5:0] op_code;
  logic [7:0] rd_value, rr_value, imm_value, io_rdata, f0;
  logic [2:0] bit_sel;
  logic [11:0] rel_offset;
  logic [15:0] z_pointer, pc0;
  logic [4:0] io_addr;
  wire op_ready, io_we, reg_we;
  wire [4:0] io_waddr;
  wire [7:0] io_wdata, reg_wdata, status_flags_register;
  wire [15:0] pc;
  int cyc, mismatches, num_checks;

  branch_skip_bitop_exec u_dut (.clock, .rst, .op_valid, .op_ready, .op_code, .rd_value, .rr_value,
    .imm_value, .bit_sel, .rel_offset, .z_pointer, .next_two_word, .io_addr, .io_rdata, .io_we,
    .io_waddr, .io_wdata, .reg_we, .reg_wdata, .pc, .status_flags_register);

  task automatic chk(input string name, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Present one operation, then count cycles until ready again
  task automatic issue(input logic [5:0] op);
    int n;
    @(negedge clock);
    op_code = op;
    op_valid = 1'b1;
    n = 0;
    while (op_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    op_valid = 1'b0;
    we_s = reg_we;
    iowe_s = io_we;
    cyc = 1;
    while (op_ready !== 1'b1 && cyc < 9)
    begin
      @(negedge clock);
      cyc++;
    end
  endtask

  task automatic t_regops;
    rd_value = 8'h80;
    issue(`OP_TEST);
    chk("test_flags", status_flags_register[3:1], 3'b010);
    issue(`OP_ZERO);
    chk("zero_data", {we_s, reg_wdata, status_flags_register[3:1]}, 12'h801);
    f0 = status_flags_register;
    issue(`OP_ONES);
    chk("ones_data", {we_s, reg_wdata}, 9'h1ff);
    chk("ones_flags", status_flags_register, f0);
    chk("ones_cyc", cyc, 1);
    $display("regops done");
  endtask

  task automatic cmpc(input logic [5:0] op, input logic [7:0] a, b, input logic [5:0] fexp);
    rd_value = a;
    rr_value = (op == `OP_CMP_IMM) ? ~b : b;
    imm_value = (op == `OP_CMP_IMM) ? b : ~b;
    issue(op);
    chk("cmp_flags", status_flags_register[5:0], fexp);
    chk("cmp_cyc", {we_s, cyc[3:0]}, 5'h01);
  endtask

  // One pass over all conditional branches; mask bit i is op 0x11+i taken
  task automatic sweep(input logic [19:0] mask, input logic [2:0] sel);
    for (int i = 0; i < 20; i++)
    begin
      pc0 = pc;
      f0 = status_flags_register;
      bit_sel = sel;
      rel_offset = 12'hffd;
      issue(6'h11 + i[5:0]);
      chk("br_pc", pc, mask[i] ? pc0 - 16'h2 : pc0 + 16'h1);
      chk("br_cyc", cyc, mask[i] ? 2 : 1);
      chk("br_flags", status_flags_register, f0);
    end
  endtask

  task automatic t_jumps;
    pc0 = pc;
    rel_offset = 12'hffe;
    issue(`OP_REL_JUMP);
    chk("rel_jump_op_pc", pc, pc0 - 16'h0001);
    chk("rel_jump_op_cyc", cyc, 2);
    z_pointer = 16'h1234;
    issue(`OP_PTR_JUMP);
    chk("ptr_jump_op", pc, 16'h1234);
    rel_offset = 12'h005;
    issue(`OP_REL_CALL);
    chk("rel_call_op_pc", pc, 16'h123a);
    chk("rel_call_op_cyc", cyc, 3);
    z_pointer = 16'h2000;
    issue(`OP_PTR_CALL);
    chk("ptr_call_op", pc, 16'h2000);
    issue(`OP_SUB_RETURN);
    chk("ret_pc", pc, 16'h123b);
    chk("ret_cyc", cyc, 4);
    issue(`OP_IRQ_RETURN);
    chk("irq_return_op_i", status_flags_register[`FLAG_I], 1'b1);
    chk("irq_return_op_pc", pc, 16'h1235);
    $display("jumps done");
  endtask

  task automatic sk(input logic [5:0] op, input logic two, input int inc);
    pc0 = pc;
    f0 = status_flags_register;
    next_two_word = two;
    issue(op);
    chk("skip_pc", pc, pc0 + inc[15:0]);
    chk("skip_cyc", cyc, inc);
    chk("skip_flags", status_flags_register, f0);
  endtask

  task automatic t_skips;
    rd_value = 8'h3c;
    rr_value = 8'h3c;
    sk(`OP_CMP_SKIP_EQ, 1'b0, 2);
    sk(`OP_CMP_SKIP_EQ, 1'b1, 3);
    rr_value = 8'hf7;
    bit_sel = 3'h3;
    sk(`OP_CMP_SKIP_EQ, 1'b0, 1);
    sk(`OP_SKIP_REGBIT_CLR, 1'b1, 3);
    sk(`OP_SKIP_REGBIT_SET, 1'b0, 1);
    io_rdata = 8'h20;
    bit_sel = 3'h5;
    sk(`OP_SKIP_IOBIT_SET, 1'b0, 2);
    sk(`OP_SKIP_IOBIT_CLR, 1'b1, 1);
    $display("skips done");
  endtask

  task automatic t_iobit;
    f0 = status_flags_register;
    io_addr = 5'h1f;
    io_rdata = 8'h00;
    bit_sel = 3'h7;
    issue(`OP_SET_IOBIT);
    chk("sbi_wr", {iowe_s, io_waddr, io_wdata, cyc[1:0]}, 16'hfe02);
    io_addr = 5'h00;
    io_rdata = 8'hff;
    bit_sel = 3'h0;
    issue(`OP_CLEAR_IOBIT);
    chk("cbi_wr", {iowe_s, io_waddr, io_wdata, cyc[1:0]}, 16'h83fa);
    chk("io_flags", status_flags_register, f0);
    $display("iobit done");
  endtask

  task automatic sh(input logic [5:0] op, input logic [7:0] a, input logic [12:0] exp);
    rd_value = a;
    issue(op);
    chk("shift", {we_s, reg_wdata, status_flags_register[3:0]}, exp);
    chk("shift_cyc", cyc, 1);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    #(20 * 5000);
    mismatches++;
    end_of_test;
  end

  initial
  begin
    {op_valid, next_two_word, op_code, rd_value, rr_value, imm_value} = '0;
    {io_rdata, bit_sel, rel_offset, z_pointer, io_addr} = '0;
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    t_regops;
    cmpc(`OP_CMP, 8'h03, 8'h05, 6'h25);
    sweep(20'ha9999, 3'h0);
    cmpc(`OP_CMP_CARRY, 8'h05, 8'h05, 6'h25);
    t_jumps;
    cmpc(`OP_CMP_IMM, 8'h80, 8'h01, 6'h28);
    sweep(20'h59a69, 3'h3);
    cmpc(`OP_CMP, 8'h05, 8'h05, 6'h02);
    sweep(20'h6a665, 3'h1);
    cmpc(`OP_CMP, 8'h03, 8'h05, 6'h25);
    sweep(20'h69999, 3'h0);
    $display("branches done");
    t_skips;
    t_iobit;
    sh(`OP_SHIFT_LEFT, 8'h81, 13'h1029);
    sh(`OP_SHIFT_RIGHT, 8'h01, 13'h100b);
    sh(`OP_ROTATE_LEFT_CARRY, 8'h40, 13'h181c);
    $display("shifts done");
    end_of_test;
  end
endmodule // branch_skip_bitop_exec_tb

bind branch_skip_bitop_exec exec_chk u_chk (.clock, .rst, .op_valid, .op_ready, .op_code, .rd_value,
  .bit_sel, .rel_offset, .z_pointer, .io_addr, .io_rdata, .io_we, .io_waddr, .io_wdata, .reg_we,
  .reg_wdata, .pc, .status_flags_register);
`default_nettype wire
